// File: hw/iit_pkg.sv
// Package: instruction classes, timing figures and issue carriers
package iit_pkg;

  // Operation classes presented by decode
  typedef enum logic [4:0] {
    IIT_OP_MOVE,          // Plain move
    IIT_OP_ALU,           // Logic and compare, not forwardable
    IIT_OP_ALU_FWD,       // Subtract, add, carry forms, cmn, mvn, cmp
    IIT_OP_SAT2,          // Saturating and halving add/subtract
    IIT_OP_SAT3,          // Doubling saturate and scalar saturate
    IIT_OP_EXT_ACC,       // Extend and accumulate
    IIT_OP_EXT,           // Plain extend, bitfield ops
    IIT_OP_SINGLE,        // One-cycle misc ops
    IIT_OP_PACK,          // Halfword pack
    IIT_OP_LOAD_WORD,     // Word load
    IIT_OP_LOAD_NARROW,   // Byte and halfword load
    IIT_OP_LOAD_MULT,     // Load multiple, doubleword load, return
    IIT_OP_STORE_MULT,    // Store multiple, doubleword store
    IIT_OP_MUL,           // 32-bit multiply
    IIT_OP_MUL_LONG,      // Long multiply
    IIT_OP_MUL_HALF,      // Halfword and dual multiply
    IIT_OP_MUL_HALF_LONG, // Halfword long accumulate
    IIT_OP_MUL_MSW,       // Most significant word multiply
    IIT_OP_BRANCH_IMM,    // Immediate branch
    IIT_OP_SERIAL         // Serializing instruction
  } iit_op_t;

  // Shift kind on the second operand or address offset
  typedef enum logic [1:0] {
    IIT_SHIFT_NONE,
    IIT_SHIFT_IMM,
    IIT_SHIFT_REG
  } iit_shift_t;

  // Decoded instruction from issue logic
  typedef struct packed {
    iit_op_t    op;        // Class
    iit_shift_t shift;     // Operand shift kind
    logic [3:0] dst0;      // First written register
    logic [3:0] dst1;      // Second written register
    logic       dst1_en;   // Second register written
    logic [3:0] src_a;     // Unshifted source
    logic [3:0] src_b;     // Possibly shifted source
    logic       src_a_en;  // Source a read
    logic       src_b_en;  // Source b read
    logic [4:0] reg_count; // Registers in a multiple (1..16)
    logic       aligned64; // Address 64-bit aligned
  } iit_instr_t;

  // Timing result for the accepted instruction
  typedef struct packed {
    logic [3:0] exec_cycles; // Execution or address cycles
    logic [2:0] latency0;    // First result latency
    logic [2:0] latency1;    // Second result latency
    logic       fast_fwd;    // Fast forward used
    logic       serialize;   // Drained before it
  } iit_timing_t;

  localparam int IIT_REGS     = 16;
  localparam int IIT_MAX_LIST = 16;
  localparam logic [3:0] IIT_CYC_1 = 4'h1;
  localparam logic [3:0] IIT_CYC_2 = 4'h2;
  localparam logic [3:0] IIT_CYC_3 = 4'h3;
  localparam logic [2:0] IIT_LAT_1 = 3'h1;
  localparam logic [2:0] IIT_LAT_2 = 3'h2;
  localparam logic [2:0] IIT_LAT_3 = 3'h3;
  localparam logic [2:0] IIT_LAT_4 = 3'h4;
  localparam logic [2:0] IIT_LAT_5 = 3'h5;

endpackage

// File: hw/iit_issue_timing.sv
// Issue timing and serialization control for the integer pipeline
`timescale 1ns/1ps
module iit_issue_timing
  import iit_pkg::*;
#(
  parameter int REGS = IIT_REGS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        in_valid,
  input  wire iit_instr_t  in_instr,
  output logic             in_ready,
  output logic             out_valid,
  output iit_instr_t       out_instr,
  output iit_timing_t      out_timing,
  output logic             busy
);

  // The scoreboard indexes registers by a four-bit field, so only a
  // sixteen-entry register file fits; any other size is refused here
  if (REGS != 16) begin : g_regs_check
    $error("REGS must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing decode

  // Address cycles for a list: ceil(n/2) aligned, floor(n/2)+1 otherwise
  // The address unit moves two registers a cycle only on an aligned
  // address; an odd start costs one single-register cycle up front
  function automatic logic [3:0] list_cycles(input logic [4:0] n,
                                             input logic       al);
    logic [4:0] c;
    c = 5'h0;
    if (al) begin
      c = 5'((n + 5'h1) >> 1);
    end else begin
      c = 5'((n >> 1) + 5'h1);
    end
    return c[3:0];
  endfunction

  // True for a consumer that can take the fast forward path
  // Only the listed add, subtract, compare and move-not class has it, and
  // a register that feeds the shifter must wait for the normal latency
  function automatic logic fwd_ok(input iit_instr_t i, input logic [3:0] r);
    logic hit_a;
    logic hit_b;
    hit_a = i.src_a_en && i.src_a == r;
    hit_b = i.src_b_en && i.src_b == r;
    // Listed ops only; a shifted source b blocks it
    return i.op == IIT_OP_ALU_FWD && (hit_a || hit_b)
           && !(hit_b && i.shift != IIT_SHIFT_NONE);
  endfunction

  iit_timing_t tim; // Timing of the instruction at the input

  // Cycle counts and latencies for each class
  // Defaults cover classes that write nothing; every branch below sets the
  // unit occupancy; load and multiply branches set their latency, ALU-type classes get theirs after the case
  always_comb begin
    tim = '0;
    tim.latency0 = IIT_LAT_1;
    tim.latency1 = IIT_LAT_1;
    unique case (in_instr.op)
      IIT_OP_MOVE: begin
        tim.exec_cycles = (in_instr.shift == IIT_SHIFT_REG) ?
                          IIT_CYC_2 : IIT_CYC_1;
      end
      // An immediate shift adds one cycle and a register shift two to the basic operations
      IIT_OP_ALU, IIT_OP_ALU_FWD: begin
        unique case (in_instr.shift)
          IIT_SHIFT_NONE: tim.exec_cycles = IIT_CYC_1;
          IIT_SHIFT_IMM:  tim.exec_cycles = IIT_CYC_2;
          default:        tim.exec_cycles = IIT_CYC_3;
        endcase
      end
      IIT_OP_SAT2:    tim.exec_cycles = IIT_CYC_2;
      IIT_OP_SAT3:    tim.exec_cycles = IIT_CYC_3;
      IIT_OP_EXT_ACC: tim.exec_cycles = IIT_CYC_3;
      IIT_OP_EXT:     tim.exec_cycles = IIT_CYC_2;
      IIT_OP_SINGLE:  tim.exec_cycles = IIT_CYC_1;
      // Pack: the shifted form costs one extra cycle
      IIT_OP_PACK: begin
        tim.exec_cycles = (in_instr.shift == IIT_SHIFT_NONE) ?
                          IIT_CYC_1 : IIT_CYC_2;
      end
      // Latencies below are the normal ones; forwarding saves one cycle
      IIT_OP_LOAD_WORD: begin
        tim.exec_cycles = IIT_CYC_1;
        if (in_instr.shift == IIT_SHIFT_REG) begin
          tim.latency0 = IIT_LAT_4;
        end else begin
          tim.latency0 = IIT_LAT_3;
        end
      end
      IIT_OP_LOAD_NARROW: begin
        tim.exec_cycles = IIT_CYC_2;
        if (in_instr.shift == IIT_SHIFT_REG) begin
          tim.latency0 = IIT_LAT_5;
        end else begin
          tim.latency0 = IIT_LAT_4;
        end
      end
      // Doubleword loads and exception returns come as two-register lists
      IIT_OP_LOAD_MULT: begin
        tim.exec_cycles = list_cycles(in_instr.reg_count,
                                      in_instr.aligned64);
        tim.latency0 = IIT_LAT_3;
      end
      // Doubleword stores and state stores come as two-register lists
      IIT_OP_STORE_MULT: begin
        tim.exec_cycles = list_cycles(in_instr.reg_count,
                                      in_instr.aligned64);
      end
      IIT_OP_MUL, IIT_OP_MUL_MSW: begin
        tim.exec_cycles = IIT_CYC_2;
        tim.latency0 = IIT_LAT_4;
      end
      // Long forms write two registers, the second one cycle later
      IIT_OP_MUL_LONG: begin
        tim.exec_cycles = IIT_CYC_3;
        tim.latency0 = IIT_LAT_4;
        tim.latency1 = IIT_LAT_5;
      end
      // Halfword and dual multiplies leave the unit after one cycle
      IIT_OP_MUL_HALF: begin
        tim.exec_cycles = IIT_CYC_1;
        tim.latency0 = IIT_LAT_3;
      end
      IIT_OP_MUL_HALF_LONG: begin
        tim.exec_cycles = IIT_CYC_2;
        tim.latency0 = IIT_LAT_3;
        tim.latency1 = IIT_LAT_4;
      end
      // Immediate branches leave the unit free and write no register
      IIT_OP_BRANCH_IMM: tim.exec_cycles = 4'h0;
      // One cycle here; the drain wait lives in the issue check
      IIT_OP_SERIAL: begin
        tim.exec_cycles = IIT_CYC_1;
        tim.serialize = 1'b1;
      end
      default: tim.exec_cycles = IIT_CYC_1;
    endcase
    // Plain ALU results are available after their execute cycles
    // Capped at seven to fit the latency field; no class reaches it
    if (in_instr.op inside {IIT_OP_MOVE, IIT_OP_ALU, IIT_OP_ALU_FWD,
        IIT_OP_SAT2, IIT_OP_SAT3, IIT_OP_EXT_ACC, IIT_OP_EXT,
        IIT_OP_SINGLE, IIT_OP_PACK}) begin
      tim.latency0 = (tim.exec_cycles > 4'h7) ? 3'h7 : tim.exec_cycles[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: cycles left before each register may be read

  // A register counter is loaded with the result latency when its writer
  // issues and counts down each cycle; a reader may issue at the edge on
  // which it would reach zero, so a value of at most one means ready
  logic [2:0] left [REGS];     // Remaining normal latency per register
  logic [REGS-1:0] from_load;  // Pending result comes from a load
  logic [3:0] exec_left;       // Execution unit occupancy remaining

  // Source is fine if ready, or one cycle early over the forward path
  function automatic logic src_ready(input iit_instr_t i, input logic [3:0] r,
                                     input logic en, input logic [2:0] l,
                                     input logic ld);
    if (!en || l <= 3'h1) return 1'b1;
    // A load result reaches a listed consumer one cycle before normal
    return ld && l == 3'h2 && fwd_ok(i, r);
  endfunction

  logic any_pending;  // Some register update or unit occupancy still outstanding
  logic srcs_ok;      // Both sources may be read now
  logic dst_ok;       // No write-after-write clash
  logic fire;         // Instruction accepted this cycle
  logic use_fwd;      // Acceptance used the forward path

  // Issue check
  always_comb begin
    // Any nonzero counter or unit occupancy counts as outstanding
    any_pending = exec_left != 4'h0;
    for (int k = 0; k < REGS; k++) begin
      if (left[k] != 3'h0) any_pending = 1'b1;
    end
    // Both sources are checked against their own counters
    srcs_ok = src_ready(in_instr, in_instr.src_a, in_instr.src_a_en,
                        left[in_instr.src_a], from_load[in_instr.src_a]) &&
              src_ready(in_instr, in_instr.src_b, in_instr.src_b_en,
                        left[in_instr.src_b], from_load[in_instr.src_b]);
    // PC is an ordinary register here
    dst_ok = left[in_instr.dst0] <= 3'h1 &&
             (!in_instr.dst1_en || left[in_instr.dst1] <= 3'h1);
    // A source still more than one cycle away can only have been met
    // through the forward path, since the source check passed
    use_fwd = (in_instr.src_a_en && left[in_instr.src_a] > 3'h1) ||
              (in_instr.src_b_en && left[in_instr.src_b] > 3'h1);
    // Serializing ops wait until nothing at all is outstanding, one
    // cycle more cautious than the read check above
    fire = in_valid && in_ready && srcs_ok && dst_ok &&
           (exec_left <= 4'h1) &&
           !(tim.serialize && any_pending);
  end

  // Load-class results take the shorter forwarded latency
  // Doubleword loads share the list class, so they forward as well
  function automatic logic is_load(input iit_op_t o);
    return o inside {IIT_OP_LOAD_WORD, IIT_OP_LOAD_NARROW,
                     IIT_OP_LOAD_MULT};
  endfunction

  // Register latency counters
  // All counters tick down together; a new writer reloads its entry, and
  // the second destination of a long form takes the later latency
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < REGS; k++) left[k] <= 3'h0;
      from_load <= '0;
    end else begin
      for (int k = 0; k < REGS; k++) begin
        if (left[k] != 3'h0) left[k] <= left[k] - 3'h1;
      end
      if (fire && tim.exec_cycles != 4'h0) begin
        left[in_instr.dst0] <= tim.latency0;
        from_load[in_instr.dst0] <= is_load(in_instr.op);
        if (in_instr.dst1_en) begin
          left[in_instr.dst1] <= tim.latency1;
          from_load[in_instr.dst1] <= 1'b0;
        end
      end
    end
  end

  // Execution unit occupancy
  // Loaded with the cycle count at issue; the next op may go once one
  // cycle is left, so an n-cycle op holds off the next for n-1 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_left <= 4'h0;
    end else if (fire) begin
      exec_left <= tim.exec_cycles;
    end else if (exec_left != 4'h0) begin
      exec_left <= exec_left - 4'h1;
    end
  end

  // Ready is a registered, conservative view
  // Held low through reset so decode cannot offer on the first edge
  always_ff @(posedge clk) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= 1'b1;
    end
  end

  // Issue output
  // The issued op and its timing hold until the next issue; busy is the
  // outstanding view of the previous cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid  <= 1'b0;
      out_instr  <= '0;
      out_timing <= '0;
      busy       <= 1'b0;
    end else begin
      out_valid <= fire;
      busy      <= any_pending;
      if (fire) begin
        out_instr  <= in_instr;
        out_timing <= tim;
        out_timing.fast_fwd <= use_fwd;
      end
    end
  end

endmodule

// File: tb/iit_checker.sv
// Checker: timing relations seen at the issue port
`timescale 1ns/1ps
module iit_checker
  import iit_pkg::*;
#(
  parameter int REGS = IIT_REGS
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        in_valid,
  input wire iit_instr_t  in_instr,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire iit_instr_t  out_instr,
  input wire iit_timing_t out_timing,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  iit_op_t    op;   // Issued class
  logic [3:0] cyc;  // Issued cycle count
  logic [3:0] lcyc; // Expected list cycles
  assign op = out_instr.op;
  assign cyc = out_timing.exec_cycles;
  assign lcyc = out_instr.aligned64 ? 4'((out_instr.reg_count + 5'h01) >> 1)
                                    : 4'((out_instr.reg_count >> 1) + 5'h01);
  // Issue of a three-cycle operation
  sequence s_issue3;
    out_valid && cyc == IIT_CYC_3;
  endsequence
  // Unit stays occupied for the two cycles after it
  sequence s_quiet2;
    !out_valid [*2];
  endsequence
  a_alu_shift_cycles: assert property (out_valid && (op == IIT_OP_ALU ||
    op == IIT_OP_ALU_FWD) |-> cyc == 4'(out_instr.shift) + 4'h1)
    else $error("alu cycle count wrong");
  a_sat_two: assert property (out_valid && op == IIT_OP_SAT2 |-> cyc == 4'h2)
    else $error("saturate cycle count wrong");
  a_dsat_three: assert property (out_valid && op == IIT_OP_SAT3 |-> cyc == 4'h3)
    else $error("doubling saturate count wrong");
  a_ext_acc_three: assert property (out_valid && op == IIT_OP_EXT_ACC |-> cyc == 4'h3)
    else $error("extend accumulate count wrong");
  a_ext_two: assert property (out_valid && op == IIT_OP_EXT |-> cyc == 4'h2)
    else $error("extend count wrong");
  a_list_cycles: assert property (out_valid && (op == IIT_OP_LOAD_MULT ||
    op == IIT_OP_STORE_MULT) |-> cyc == lcyc) else $error("list cycles wrong");
  a_long_mul_lat: assert property (out_valid && op == IIT_OP_MUL_LONG |->
    out_timing.latency0 == IIT_LAT_4 && out_timing.latency1 == IIT_LAT_5)
    else $error("long multiply latency wrong");
  a_branch_free: assert property (out_valid && op == IIT_OP_BRANCH_IMM |-> cyc == 4'h0)
    else $error("branch used cycles");
  a_fwd_only_listed: assert property (out_valid && out_timing.fast_fwd |->
    op == IIT_OP_ALU_FWD) else $error("forward to unlisted class");
  a_serial_mark: assert property (out_valid && op == IIT_OP_SERIAL |->
    out_timing.serialize) else $error("serial flag missing");
  a_occupancy_hold: assert property (s_issue3 |=> s_quiet2)
    else $error("issue inside occupancy");
endmodule
bind iit_issue_timing iit_checker #(.REGS(REGS)) i_chk (.clk(clk), .rst(rst),
  .in_valid(in_valid), .in_instr(in_instr), .in_ready(in_ready),
  .out_valid(out_valid), .out_instr(out_instr), .out_timing(out_timing),
  .busy(busy));

// File: tb/iit_decode_model.sv
// Decode-side model: offers instructions and holds them until issued
`timescale 1ns/1ps
module iit_decode_model
  import iit_pkg::*;
(
  input  wire logic clk,
  input  wire logic out_valid,
  output logic      in_valid,
  output iit_instr_t in_instr
);
  int cyc; // Edge counter for issue stamps
  initial begin
    in_valid = 1'b0;
    in_instr = '0;
    cyc = 0;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Offer after an optional pause, hold until the issue pulse shows
  task automatic offer(input iit_instr_t ins, input int slow, output int st);
    int n;
    n = 0;
    if (slow > 0) begin
      in_valid = 1'b0;
      repeat (slow) begin
        @(posedge clk);
        #1;
      end
    end
    in_instr = ins;
    in_valid = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (out_valid !== 1'b1 && n < 200);
    st = (n < 200) ? cyc : -1;
  endtask
  // Withdraw the request
  task automatic idle();
    in_valid = 1'b0;
  endtask
endmodule

// File: tb/instr_issue_timing_model_tb.sv
// Testbench: issue timing, forwarding and serialization
`timescale 1ns/1ps
module instr_issue_timing_model_tb;
  import iit_pkg::*;
  logic        clk, rst, in_valid, in_ready, out_valid, busy;
  iit_instr_t  in_instr, out_instr, ins;
  iit_timing_t out_timing;
  int          err_total, total_checks, st, s0;
  logic [31:0] seed;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  iit_issue_timing #(.REGS(IIT_REGS)) i_dut (.clk(clk), .rst(rst),
    .in_valid(in_valid), .in_instr(in_instr), .in_ready(in_ready),
    .out_valid(out_valid), .out_instr(out_instr),
    .out_timing(out_timing), .busy(busy));
  iit_decode_model i_dec (.clk(clk), .out_valid(out_valid),
    .in_valid(in_valid), .in_instr(in_instr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected execution or address cycles
  function automatic logic [3:0] ecyc(iit_instr_t i);
    case (i.op)
      IIT_OP_MOVE: return (i.shift == IIT_SHIFT_REG) ? 4'h2 : 4'h1;
      IIT_OP_ALU, IIT_OP_ALU_FWD: return 4'(i.shift) + 4'h1;
      IIT_OP_SAT2, IIT_OP_EXT, IIT_OP_MUL, IIT_OP_MUL_HALF_LONG,
      IIT_OP_MUL_MSW, IIT_OP_LOAD_NARROW: return 4'h2;
      IIT_OP_SAT3, IIT_OP_EXT_ACC, IIT_OP_MUL_LONG: return 4'h3;
      IIT_OP_PACK: return (i.shift == IIT_SHIFT_NONE) ? 4'h1 : 4'h2;
      IIT_OP_LOAD_MULT, IIT_OP_STORE_MULT: return i.aligned64 ?
        4'((i.reg_count + 5'h01) >> 1) : 4'((i.reg_count >> 1) + 5'h01);
      IIT_OP_BRANCH_IMM: return 4'h0;
      default: return 4'h1;
    endcase
  endfunction
  // Expected first-result latency without forwarding
  function automatic logic [2:0] elat(iit_instr_t i);
    case (i.op)
      IIT_OP_LOAD_WORD: return (i.shift == IIT_SHIFT_REG) ? 3'h4 : 3'h3;
      IIT_OP_LOAD_NARROW: return (i.shift == IIT_SHIFT_REG) ? 3'h5 : 3'h4;
      IIT_OP_LOAD_MULT, IIT_OP_MUL_HALF, IIT_OP_MUL_HALF_LONG: return 3'h3;
      IIT_OP_MUL, IIT_OP_MUL_LONG, IIT_OP_MUL_MSW: return 3'h4;
      default: return 3'(ecyc(i));
    endcase
  endfunction
  // Build an instruction; register 0 means no source
  function automatic iit_instr_t mk(iit_op_t op, iit_shift_t sh,
                                    logic [3:0] d, logic [3:0] a, logic [3:0] b);
    iit_instr_t i;
    i = '0;
    i.op = op;
    i.shift = sh;
    i.dst0 = d;
    i.src_a = a;
    i.src_b = b;
    i.src_a_en = (a != 4'h0);
    i.src_b_en = (b != 4'h0);
    i.reg_count = 5'h01;
    i.aligned64 = 1'b1;
    return i;
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Let at least one edge pass, then wait for the scoreboard to empty
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 100);
    if (n >= 100) err_total++;
  endtask
  // Two back-to-back offers; returns issue spacing
  task automatic pair(input iit_instr_t a, input iit_instr_t b, output int gap);
    wait_idle();
    i_dec.offer(a, 0, s0);
    i_dec.offer(b, 0, st);
    i_dec.idle();
    gap = st - s0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  initial begin
    int g;
    err_total = 0;
    total_checks = 0;
    seed = 32'h7;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check("rst ready", 32'(in_ready), 32'h0);
    check("rst valid", 32'(out_valid), 32'h0);
    check("rst busy", 32'(busy), 32'h0);
    @(posedge clk);
    #1;
    check("ready", 32'(in_ready), 32'h1);
    // Every class once per round with random fields, each in isolation
    for (int k = 0; k < 60; k++) begin
      ins = iit_instr_t'(rnd());
      ins.op = iit_op_t'(k % 20);
      ins.shift = iit_shift_t'(ins.op inside {IIT_OP_MOVE, IIT_OP_ALU,
        IIT_OP_ALU_FWD, IIT_OP_LOAD_WORD, IIT_OP_LOAD_NARROW} ? rnd() % 3 :
        ins.op == IIT_OP_PACK ? rnd() % 2 : 0);
      ins.src_a_en = 1'b0;
      ins.src_b_en = 1'b0;
      ins.reg_count = (k < 20) ? 5'h10 : 5'(rnd() % 16 + 1);
      wait_idle();
      i_dec.offer(ins, int'(rnd() % 3), st);
      i_dec.idle();
      check("taken", 32'(st < 0), 32'h0);
      check("instr", out_instr, ins);
      check("cycles", 32'(out_timing.exec_cycles), 32'(ecyc(ins)));
      if (!(ins.op inside {IIT_OP_STORE_MULT, IIT_OP_BRANCH_IMM, IIT_OP_SERIAL}))
        check("lat0", 32'(out_timing.latency0), 32'(elat(ins)));
      if (ins.op inside {IIT_OP_MUL_LONG, IIT_OP_MUL_HALF_LONG})
        check("lat1", 32'(out_timing.latency1), 32'(elat(ins) + 3'h1));
      check("ser", 32'(out_timing.serialize), 32'(ins.op == IIT_OP_SERIAL));
    end
    pair(mk(IIT_OP_LOAD_WORD, IIT_SHIFT_NONE, 4'h2, 4'h0, 4'h0),
         mk(IIT_OP_ALU_FWD, IIT_SHIFT_NONE, 4'h3, 4'h2, 4'h0), g);
    check("fwd gap", 32'(g), 32'h2);
    check("fwd", 32'(out_timing.fast_fwd), 32'h1);
    pair(mk(IIT_OP_LOAD_WORD, IIT_SHIFT_NONE, 4'h2, 4'h0, 4'h0),
         mk(IIT_OP_ALU, IIT_SHIFT_NONE, 4'h3, 4'h2, 4'h0), g);
    check("alu gap", 32'(g), 32'h3);
    pair(mk(IIT_OP_LOAD_WORD, IIT_SHIFT_NONE, 4'h2, 4'h0, 4'h0),
         mk(IIT_OP_ALU_FWD, IIT_SHIFT_IMM, 4'h3, 4'h0, 4'h2), g);
    check("shift gap", 32'(g), 32'h3);
    check("shift fwd", 32'(out_timing.fast_fwd), 32'h0);
    pair(mk(IIT_OP_LOAD_NARROW, IIT_SHIFT_NONE, 4'hF, 4'h0, 4'h0),
         mk(IIT_OP_ALU_FWD, IIT_SHIFT_NONE, 4'h3, 4'hF, 4'h0), g);
    check("narrow gap", 32'(g), 32'h3);
    pair(mk(IIT_OP_LOAD_MULT, IIT_SHIFT_NONE, 4'h2, 4'h0, 4'h0),
         mk(IIT_OP_ALU_FWD, IIT_SHIFT_NONE, 4'h3, 4'h2, 4'h0), g);
    check("list gap", 32'(g), 32'h2);
    pair(mk(IIT_OP_ALU, IIT_SHIFT_REG, 4'h5, 4'h0, 4'h0),
         mk(IIT_OP_ALU, IIT_SHIFT_NONE, 4'h6, 4'h0, 4'h0), g);
    check("occupy gap", 32'(g), 32'h3);
    pair(mk(IIT_OP_MUL, IIT_SHIFT_NONE, 4'h3, 4'h0, 4'h0),
         mk(IIT_OP_ALU, IIT_SHIFT_NONE, 4'h4, 4'h3, 4'h0), g);
    check("mul gap", 32'(g), 32'h4);
    check("busy", 32'(busy), 32'h1);
    ins = mk(IIT_OP_MUL_LONG, IIT_SHIFT_NONE, 4'h4, 4'h0, 4'h0);
    ins.dst1 = 4'h5;
    ins.dst1_en = 1'b1;
    pair(ins, mk(IIT_OP_SERIAL, IIT_SHIFT_NONE, 4'h0, 4'h0, 4'h0), g);
    check("drain", 32'(g >= 5), 32'h1);
    check("drained", 32'(busy), 32'h0);
    summarize();
  end
endmodule
